// ### hdl/ocm_pkg.sv
// Function
// [RL1] the two-bit response field in bits 7-6 picks latched fault, cycle-by-cycle, warning only or monitor off.
// [RL2] the two-bit deglitch field in bits 5-4 needs the comparator to hold 1, 2, 4 or 8 us before a fault counts.
// [RL3] after a fault the gate sink strength is the programmed sink current or a fixed 8, 31 or 62 mA code.
// [RL4] one bit picks the gate compare level for handshake and gate fault checks: 1.4 V clear, 1.0 V set.
// [RL5] with per-half-bridge shutdown set and bridge mode 00b or 11b a fault stops only its own half-bridge.
// [RL6] the upper nibble of the threshold register sets the high-side trip level, resetting to code 1101b.
// [RL7] the lower nibble sets the low-side trip level with the same sixteen codes, resetting to 1101b.
// [RL8] the offline diagnostic enable puts the comparators in real-time monitoring and allows the sources.
// [RL9] the four source enables act only while the offline diagnostic enable is set.
// [RL10] the monitor control register sits at 9h and resets to 20h.
// [RL11] the threshold register sits at ah and resets to ddh.
// [RL12] the diagnostic register sits at bh, resets to zero and keeps three reserved read/write bits.
// [RL13] the monitor is blanked for the programmed gate drive time of 96, 2, 4 or 8 us after each gate edge.
// [RL14] cycle-by-cycle faults release at the next commanded edge; latched faults hold until the host clears.
package ocm_pkg;
    localparam logic [3:0] OCM_ADDR_CTRL  = 4'h9;
    localparam logic [3:0] OCM_ADDR_LVL   = 4'ha;
    localparam logic [3:0] OCM_ADDR_DIAG  = 4'hb;
    localparam logic [7:0] OCM_RST_CTRL   = 8'h20;
    localparam logic [7:0] OCM_RST_LVL    = 8'hdd;
    localparam logic [7:0] OCM_RST_DIAG   = 8'h00;
    localparam int         OCM_MODE_LSB   = 6;
    localparam int         OCM_DG_LSB     = 4;
    localparam int         OCM_PD_LSB     = 2;
    localparam int         OCM_VGS_BIT    = 1;
    localparam int         OCM_IND_BIT    = 0;
    localparam int         OCM_HS_LSB     = 4;
    localparam int         OCM_LS_LSB     = 0;
    localparam int         OCM_DIAG_EN    = 4;
    localparam int         OCM_PU1_BIT    = 3;
    localparam int         OCM_PD1_BIT    = 2;
    localparam int         OCM_PU2_BIT    = 1;
    localparam int         OCM_PD2_BIT    = 0;
    localparam int         OCM_CLK_MHZ    = 50;
    localparam int         OCM_DG_US      = 1;
    localparam int         OCM_DG_CYC     = OCM_DG_US * OCM_CLK_MHZ;
    localparam int         OCM_BLK0_US    = 96;
    localparam int         OCM_BLK0_CYC   = OCM_BLK0_US * OCM_CLK_MHZ;
    localparam int         OCM_BLK1_US    = 2;
    localparam int         OCM_BLK1_CYC   = OCM_BLK1_US * OCM_CLK_MHZ;
    localparam int         OCM_BLK2_US    = 4;
    localparam int         OCM_BLK2_CYC   = OCM_BLK2_US * OCM_CLK_MHZ;
    localparam int         OCM_BLK3_US    = 8;
    localparam int         OCM_BLK3_CYC   = OCM_BLK3_US * OCM_CLK_MHZ;

    typedef enum logic [1:0] {
        OCM_MODE_LATCH = 2'b00,
        OCM_MODE_CBC   = 2'b01,
        OCM_MODE_WARN  = 2'b10,
        OCM_MODE_OFF   = 2'b11
    } ocm_mode_t;

    // decoded configuration handed to the analog side
    typedef struct packed {
        logic [1:0] post_fault_pulldown_strength;
        logic       gate_voltage_compare_level;
        logic [3:0] high_side_trip_level;
        logic [3:0] low_side_trip_level;
        logic       offline_diag_enable;
        logic [3:0] source_en;
    } ocm_cfg_t;
endpackage : ocm_pkg

// ### hdl/ocm_channel.sv
`timescale 1ns/1ps
`default_nettype none
// one comparator channel: blanking, deglitch and fault hold
module ocm_channel #(
    parameter int BLK0_CYC = ocm_pkg::OCM_BLK0_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       cmp,
    input  wire logic       gate_edge,
    input  wire logic [1:0] mode,
    input  wire logic [1:0] dg_sel,
    input  wire logic [1:0] blk_sel,
    input  wire logic       live_mon,
    input  wire logic       clear,
    output logic            trip,
    output logic            fault
);
    logic [12:0] blk_q;
    logic [8:0]  dg_q;
    logic [8:0]  dg_lim;
    logic        held_q;

    // deglitch limit is 1 us shifted by the code
    assign dg_lim = 9'(ocm_pkg::OCM_DG_CYC << dg_sel); // RL2

    // blanking restarts at every commanded gate edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            blk_q <= 13'h0000;
        end else if (gate_edge) begin
            case (blk_sel) // RL13
                2'b00:   blk_q <= 13'(BLK0_CYC);
                2'b01:   blk_q <= 13'(ocm_pkg::OCM_BLK1_CYC);
                2'b10:   blk_q <= 13'(ocm_pkg::OCM_BLK2_CYC);
                default: blk_q <= 13'(ocm_pkg::OCM_BLK3_CYC);
            endcase
        end else if (blk_q != 13'h0000) begin
            blk_q <= blk_q - 13'h0001;
        end
    end

    // realtime diagnostics bypass blanking so the host sees the deglitched level
    always_ff @(posedge core_clk) begin
        if (rst || !cmp || (blk_q != 13'h0000 && !live_mon)) begin
            dg_q <= 9'h000;
        end else if (dg_q != dg_lim) begin
            dg_q <= dg_q + 9'h001;
        end
    end

    assign trip = cmp && (dg_q == dg_lim);

    // latched holds to host clear, cycle-by-cycle drops at next edge
    always_ff @(posedge core_clk) begin
        if (rst || mode == ocm_pkg::OCM_MODE_OFF) begin // RL1
            held_q <= 1'b0;
        end else if (trip && !live_mon) begin
            held_q <= 1'b1; // set beats clear
        end else if ((mode == ocm_pkg::OCM_MODE_CBC && gate_edge) // RL14
                     || (mode == ocm_pkg::OCM_MODE_LATCH && clear)
                     || mode == ocm_pkg::OCM_MODE_WARN) begin
            held_q <= 1'b0;
        end
    end

    assign fault = held_q && (mode != ocm_pkg::OCM_MODE_WARN);
endmodule : ocm_channel
`default_nettype wire

// ### hdl/ocm_top.sv
`timescale 1ns/1ps
`default_nettype none
// overcurrent monitor configuration bank with four comparator channels
module ocm_top #(
    parameter int BLK0_CYC = ocm_pkg::OCM_BLK0_CYC
) (
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    input  wire logic [3:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic [1:0]      bridge_control_mode,
    input  wire logic [3:0]      cmp_pin,
    input  wire logic [3:0]      gate_cmd,
    input  wire logic            fault_clear,
    input  wire logic [1:0]      gate_drive_blanking_time,
    output logic [7:0]           reg_rdata,
    output ocm_pkg::ocm_cfg_t    cfg,
    output logic [3:0]           trip_status,
    output logic                 drain_source_overcurrent_fault,
    output logic                 overcurrent_warning,
    output logic [1:0]           bridge_shutdown,
    output logic                 sink_override
);
    logic [7:0] ctrl_q;
    logic [7:0] lvl_q;
    logic [7:0] diag_q;
    logic [3:0] cmp_m_q;
    logic [3:0] cmp_s_q;
    logic [3:0] cmd_q;
    logic [3:0] trip_w;
    logic [3:0] fault_w;
    logic [1:0] mode;
    logic       indep;

    assign mode  = ctrl_q[ocm_pkg::OCM_MODE_LSB +: 2]; // RL1
    // independent shutdown only in the half-bridge modes
    assign indep = ctrl_q[ocm_pkg::OCM_IND_BIT] // RL5
                   && (bridge_control_mode == 2'b00 || bridge_control_mode == 2'b11);

    // register writes; reserved diag bits are plain storage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= ocm_pkg::OCM_RST_CTRL; // RL10
            lvl_q  <= ocm_pkg::OCM_RST_LVL;  // RL11
            diag_q <= ocm_pkg::OCM_RST_DIAG; // RL12
        end else if (reg_wr) begin
            case (reg_addr)
                ocm_pkg::OCM_ADDR_CTRL: ctrl_q <= reg_wdata;
                ocm_pkg::OCM_ADDR_LVL:  lvl_q  <= reg_wdata;
                ocm_pkg::OCM_ADDR_DIAG: diag_q <= reg_wdata;
                default:                ;
            endcase
        end
    end

    // registered read port, unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ocm_pkg::OCM_ADDR_CTRL: reg_rdata <= ctrl_q;
                ocm_pkg::OCM_ADDR_LVL:  reg_rdata <= lvl_q;
                ocm_pkg::OCM_ADDR_DIAG: reg_rdata <= diag_q;
                default:                reg_rdata <= 8'h00;
            endcase
        end
    end

    // comparator pins are asynchronous: two flops before use
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmp_m_q <= 4'h0;
            cmp_s_q <= 4'h0;
            cmd_q   <= 4'h0;
        end else begin
            cmp_m_q <= cmp_pin;
            cmp_s_q <= cmp_m_q;
            cmd_q   <= gate_cmd;
        end
    end

    // channel order: hs1, ls1, hs2, ls2
    for (genvar i = 0; i < 4; i++) begin : g_ch
        ocm_channel #(
            .BLK0_CYC (BLK0_CYC)
        ) u_ch (
            .core_clk  (core_clk),
            .rst       (rst),
            .cmp       (cmp_s_q[i]),
            .gate_edge (gate_cmd[i] != cmd_q[i]),
            .mode      (mode),
            .dg_sel    (ctrl_q[ocm_pkg::OCM_DG_LSB +: 2]),
            .blk_sel   (gate_drive_blanking_time),
            .live_mon  (diag_q[ocm_pkg::OCM_DIAG_EN]), // RL8
            .clear     (fault_clear),
            .trip      (trip_w[i]),
            .fault     (fault_w[i])
        );
    end

    // configuration out; sources gated by the diag enable
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg <= '0;
        end else begin
            cfg.post_fault_pulldown_strength <= ctrl_q[ocm_pkg::OCM_PD_LSB +: 2]; // RL3
            cfg.gate_voltage_compare_level   <= ctrl_q[ocm_pkg::OCM_VGS_BIT]; // RL4
            cfg.high_side_trip_level         <= lvl_q[ocm_pkg::OCM_HS_LSB +: 4]; // RL6
            cfg.low_side_trip_level          <= lvl_q[ocm_pkg::OCM_LS_LSB +: 4]; // RL7
            cfg.offline_diag_enable          <= diag_q[ocm_pkg::OCM_DIAG_EN]; // RL8
            cfg.source_en <= diag_q[ocm_pkg::OCM_DIAG_EN] ? diag_q[3:0] : 4'h0; // RL9
        end
    end

    // fault outputs and shutdown decision
    always_ff @(posedge core_clk) begin
        if (rst) begin
            trip_status                    <= 4'h0;
            drain_source_overcurrent_fault <= 1'b0;
            overcurrent_warning            <= 1'b0;
            bridge_shutdown                <= 2'b00;
            sink_override                  <= 1'b0;
        end else begin
            trip_status                    <= trip_w;
            drain_source_overcurrent_fault <= |fault_w;
            overcurrent_warning <= (mode == ocm_pkg::OCM_MODE_WARN) && (|trip_w);
            if (indep) begin
                bridge_shutdown <= {|fault_w[3:2], |fault_w[1:0]}; // RL5
            end else begin
                bridge_shutdown <= {2{|fault_w}};
            end
            // a nonzero strength code overrides the programmed sink current
            sink_override <= (|fault_w) && (ctrl_q[ocm_pkg::OCM_PD_LSB +: 2] != 2'b00); // RL3
        end
    end
endmodule : ocm_top
`default_nettype wire

// ### sim/ocm_props.sv
`timescale 1ns/1ps
`default_nettype none
// watches register port and fault outputs of the bank
module ocm_chk (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [3:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [3:0]        cmp_pin,
    input wire logic [7:0]        reg_rdata,
    input wire ocm_pkg::ocm_cfg_t cfg,
    input wire logic [3:0]        trip_status,
    input wire logic              drain_source_overcurrent_fault,
    input wire logic              overcurrent_warning,
    input wire logic [1:0]        bridge_shutdown,
    input wire logic              sink_override
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // write and read steps; config lags a write by two edges
    sequence s_lvl_wr;
        reg_wr && reg_addr == 4'ha;
    endsequence
    sequence s_bad_rd;
        reg_rd && !(reg_addr inside {4'h9, 4'ha, 4'hb});
    endsequence
    chk_lvl_decode: assert property (s_lvl_wr |-> ##2
        {cfg.high_side_trip_level, cfg.low_side_trip_level} == $past(reg_wdata, 2))
        else $error("trip levels not decoded");
    chk_unmapped_zero: assert property (s_bad_rd |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    chk_source_gate: assert property (!cfg.offline_diag_enable |-> cfg.source_en == 4'h0)
        else $error("source on without diag");
    // trip status and warning are registered on the same edge, so the past term is never needed
    chk_warn_cause: assert property (overcurrent_warning |->
        trip_status != 4'h0 || $past(trip_status) != 4'h0)
        else $error("warning without trip");
    chk_sink_fault: assert property (sink_override |-> drain_source_overcurrent_fault)
        else $error("sink override without fault");
    chk_stop_fault: assert property (bridge_shutdown != 2'b00 |-> drain_source_overcurrent_fault)
        else $error("shutdown without fault");
    chk_deglitch_wait: assert property ($rose(cmp_pin[0]) |=> !trip_status[0] [*8])
        else $error("trip before deglitch");
endmodule : ocm_chk
bind ocm_top ocm_chk u_chk (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .cmp_pin, .reg_rdata, .cfg, .trip_status, .drain_source_overcurrent_fault,
    .overcurrent_warning, .bridge_shutdown, .sink_override);
`default_nettype wire

// ### sim/ocm_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the register port
module ocm_host (
    input  wire logic       core_clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [3:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // idle lines show the inverse so a stale value never matches
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        // one idle edge so a following call never reassigns the strobe in this step
        @(posedge core_clk);
    endtask : wr
    // data is taken one edge after the read edge, where it stands
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge core_clk);
        d = reg_rdata;
    endtask : rd
endmodule : ocm_host
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic              core_clk, rst, reg_wr, reg_rd, fault_clear;
    logic              drain_source_overcurrent_fault, overcurrent_warning, sink_override;
    logic [3:0]        reg_addr, cmp_pin, gate_cmd, trip_status;
    logic [7:0]        reg_wdata, reg_rdata, rv;
    logic [1:0]        bridge_control_mode, gate_drive_blanking_time, bridge_shutdown;
    ocm_pkg::ocm_cfg_t cfg;
    int                n;
    int                n_errors = 0;
    int                check_count = 0;
    // ctrl, bridge mode, comparator, fault warn shutdown sink, fault after edge
    localparam logic [19:0] TBL [6] = '{{8'h0d, 2'b00, 4'h4, 6'b101011},
        {8'h01, 2'b01, 4'h1, 6'b101101}, {8'h01, 2'b11, 4'h2, 6'b100101},
        {8'h80, 2'b00, 4'h1, 6'b010000}, {8'h40, 2'b00, 4'h8, 6'b101100},
        {8'hc0, 2'b00, 4'h1, 6'b000000}};
    // blanking counts per code; a short first code keeps the run brief
    localparam int     BLK [4] = '{100, ocm_pkg::OCM_BLK1_CYC, ocm_pkg::OCM_BLK2_CYC,
        ocm_pkg::OCM_BLK3_CYC};
    ocm_top #(.BLK0_CYC(BLK[0])) u_dut (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .bridge_control_mode, .cmp_pin, .gate_cmd, .fault_clear,
        .gate_drive_blanking_time, .reg_rdata, .cfg, .trip_status,
        .drain_source_overcurrent_fault, .overcurrent_warning, .bridge_shutdown, .sink_override);
    ocm_host u_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        u_host.rd(a, rv);
        chk("rdata", e, rv);
    endtask : rchk
    // raise a comparator and count edges until it trips, bounded
    task automatic fire(input logic [3:0] c, output int k);
        cmp_pin <= c;
        for (k = 0; k < 2000 && trip_status === 4'h0; k++) begin
            @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
    endtask : fire
    // let the synchroniser drain first: a live trip would beat the clear
    task automatic clr;
        repeat (4) @(posedge core_clk);
        fault_clear <= 1'b1;
        @(posedge core_clk);
        fault_clear <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask : clr
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    // watchdog far beyond the longest expected run
    initial begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        give_verdict;
    end
    initial begin
        {rst, fault_clear, bridge_control_mode, cmp_pin, gate_cmd} = {1'b1, 11'h000};
        gate_drive_blanking_time = 2'b01;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rchk(4'h9, 8'h20);
        rchk(4'ha, 8'hdd);
        rchk(4'hb, 8'h00);
        rchk(4'h3, 8'h00);
        u_host.wr(4'ha, 8'h5a);
        u_host.wr(4'h9, 8'h0e);
        u_host.wr(4'hb, 8'h0f);
        u_host.wr(4'h5, 8'hff);
        repeat (2) @(posedge core_clk);
        chk("lvl", 8'h5a, {cfg.high_side_trip_level, cfg.low_side_trip_level});
        chk("pd", 8'h07, {5'h0, cfg.post_fault_pulldown_strength, cfg.gate_voltage_compare_level});
        chk("src", 8'h00, {4'h0, cfg.source_en});
        rchk(4'h9, 8'h0e);
        u_host.wr(4'hb, 8'hff);
        rchk(4'hb, 8'hff);
        @(posedge core_clk);
        chk("diag", 8'h1f, {3'h0, cfg.offline_diag_enable, cfg.source_en});
        u_host.wr(4'hb, 8'h00);
        repeat (200) @(posedge core_clk);
        // every deglitch code in latched mode, shared shutdown
        for (int d = 0; d < 4; d++) begin
            u_host.wr(4'h9, 8'(d << 4));
            fire(4'h1, n);
            chk("dg", 8'h01, {7'h0, n >= (ocm_pkg::OCM_DG_CYC << d)
                && n <= (ocm_pkg::OCM_DG_CYC << d) + 6});
            chk("latch", 8'h07, {5'h0, drain_source_overcurrent_fault, bridge_shutdown});
            cmp_pin <= 4'h0;
            clr;
            chk("clr", 8'h00, {7'h0, drain_source_overcurrent_fault});
        end
        // modes, shutdown scope and pulldown from the table
        for (int t = 0; t < 6; t++) begin
            u_host.wr(4'h9, TBL[t][19:12]);
            bridge_control_mode <= TBL[t][11:10];
            fire(TBL[t][9:6], n);
            chk("trip", {4'h0, TBL[t][9:6]}, {4'h0, trip_status});
            chk("resp", {3'h0, TBL[t][5:1]}, {3'h0, drain_source_overcurrent_fault,
                overcurrent_warning, bridge_shutdown, sink_override});
            cmp_pin <= 4'h0;
            repeat (8) @(posedge core_clk);
            gate_cmd <= ~gate_cmd;
            repeat (4) @(posedge core_clk);
            chk("edge", {7'h0, TBL[t][0]}, {7'h0, drain_source_overcurrent_fault});
            clr;
        end
        // each blanking code holds off the deglitch count after a gate edge
        u_host.wr(4'h9, 8'h00);
        for (int b = 0; b < 4; b++) begin
            gate_drive_blanking_time <= 2'(b);
            @(posedge core_clk);
            gate_cmd <= ~gate_cmd;
            fire(4'h1, n);
            chk("blank", 8'h01, {7'h0, n >= BLK[b] + ocm_pkg::OCM_DG_CYC
                && n <= BLK[b] + ocm_pkg::OCM_DG_CYC + 6});
            cmp_pin <= 4'h0;
            clr;
        end
        give_verdict;
    end
endmodule : tb_top
`default_nettype wire
